// ==== logic/smc_consts.svh ====
// register map, field positions, reset values and settling exponents
`ifndef SMC_CONSTS_SVH
`define SMC_CONSTS_SVH

`define SMC_PWR_CTL_ADDR 32'hfffff800
`define SMC_STAT_ADDR 32'hfffff804
`define SMC_PWR_MODE_ADDR 32'h0ffff820
`define SMC_SETTLE_SEL_ADDR 32'hfffff6c0

`define SMC_PWR_CTL_RST 8'h00
`define SMC_PWR_MODE_RST 8'h00
`define SMC_SETTLE_SEL_RST 8'h01

`define SMC_STBY_REQ_BIT 1
`define SMC_INTDIS_BIT 4
`define SMC_PWR_CTL_WMASK 8'h12
`define SMC_STOP_SEL_BIT 0
`define SMC_SUBCLK_DIS_BIT 7
`define SMC_PWR_MODE_WMASK 8'h81
`define SMC_SETTLE_SEL_WMASK 8'h07

`define SMC_SETTLE_EXP_C0 13
`define SMC_SETTLE_EXP_C1 15
`define SMC_SETTLE_EXP_C2 16
`define SMC_CNT_W 22

`endif

// ==== logic/smc_pkg.sv ====
// types shared by the standby mode controller
`include "smc_consts.svh"
package smc_pkg;

  typedef enum logic [2:0] {
    SMC_RUN    = 3'b000,
    SMC_HALT   = 3'b001,
    SMC_IDLE   = 3'b010,
    SMC_STOP   = 3'b011,
    SMC_SETTLE = 3'b100
  } smc_state_t;

  typedef struct packed {
    smc_state_t state;
    logic stby_req;
    logic int_wake_dis;
    logic [7:0] pwr_mode;
    logic [7:0] settle_sel;
    logic settle_go;
    logic cpu_clk_en;
    logic periph_clk_en;
    logic main_osc_en;
    logic subclk_osc_en;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } smc_main_t;

  typedef struct packed {
    logic busy;
    logic done;
    logic [`SMC_CNT_W-1:0] cnt;
    logic [`SMC_CNT_W-1:0] limit;
  } smc_tmr_t;

endpackage

// ==== logic/smc_wake_filter.sv ====
// sorts interrupt requests into halt and standby release conditions
`timescale 1ns/1ps
`default_nettype none
module smc_wake_filter
  import smc_pkg::*;
(
  // requests from the interrupt controller
  input wire logic nmi_req,
  input wire logic int_req,
  // standby release masking
  input wire logic int_wake_dis,
  // release conditions
  output logic halt_wake,
  output logic standby_wake
);

  // halt always ends on an unmasked request, whatever the standby masking says
  always_comb begin
    halt_wake = nmi_req | int_req;
    standby_wake = nmi_req | (int_req & ~int_wake_dis);
  end

endmodule
`default_nettype wire

// ==== logic/smc_settle_timer.sv ====
// oscillator settling counter, counts only while the oscillator runs
`timescale 1ns/1ps
`default_nettype none
module smc_settle_timer
  import smc_pkg::*;
#(
  parameter int unsigned EXP_C0 = `SMC_SETTLE_EXP_C0,
  parameter int unsigned EXP_C1 = `SMC_SETTLE_EXP_C1,
  parameter int unsigned EXP_C2 = `SMC_SETTLE_EXP_C2
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic start,
  input wire logic [2:0] code,
  input wire logic osc_running,
  // result
  output logic done
);

  smc_tmr_t t_r, t_nxt;

  function automatic logic [`SMC_CNT_W-1:0] settle_len(input logic [2:0] c);
    int unsigned e;
    case (c)
      3'h0: e = EXP_C0;
      3'h1: e = EXP_C1;
      default: e = EXP_C2 + 32'(c) - 32'd2;
    endcase
    return `SMC_CNT_W'(1) << e;
  endfunction

  always_comb begin
    t_nxt = t_r;
    t_nxt.done = 1'b0;
    if (start) begin
      t_nxt.busy = 1'b1;
      t_nxt.cnt = '0;
      t_nxt.limit = settle_len(code);
    end else if (t_r.busy && osc_running) begin
      if (t_r.cnt == t_r.limit - `SMC_CNT_W'(1)) begin
        t_nxt.busy = 1'b0;
        t_nxt.done = 1'b1;
      end else begin
        t_nxt.cnt = t_r.cnt + `SMC_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      t_r <= '0;
    end else begin
      t_r <= t_nxt;
    end
  end

  assign done = t_r.done;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  count_frozen_a: assert property (t_r.busy && !osc_running && !start |=> t_r.cnt == $past(t_r.cnt))
    else $error("settle count moved while oscillator stopped");
  done_at_limit_a: assert property (t_r.done |-> $past(t_r.cnt) == $past(t_r.limit) - 1)
    else $error("settle done before full count");

endmodule
`default_nettype wire

// ==== logic/smc_standby_ctrl.sv ====
// standby mode controller: apb registers, run/halt/idle/stop sequencing
`timescale 1ns/1ps
`default_nettype none
module smc_standby_ctrl
  import smc_pkg::*;
#(
  parameter int unsigned SETTLE_EXP_C0 = `SMC_SETTLE_EXP_C0,
  parameter int unsigned SETTLE_EXP_C1 = `SMC_SETTLE_EXP_C1,
  parameter int unsigned SETTLE_EXP_C2 = `SMC_SETTLE_EXP_C2
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // cpu core
  input wire logic halt_instr,
  input wire logic nmi_req,
  input wire logic int_req,
  // oscillators
  input wire logic osc_running,
  output logic main_osc_en,
  output logic subclk_osc_en,
  // clock gates
  output logic cpu_clk_en,
  output logic periph_clk_en,
  // status
  output logic [2:0] mode
);

  smc_main_t s_r, s_nxt;
  logic halt_wake;
  logic standby_wake;
  logic settle_done;

  smc_wake_filter u_wake (
    .nmi_req(nmi_req),
    .int_req(int_req),
    .int_wake_dis(s_r.int_wake_dis),
    .halt_wake(halt_wake),
    .standby_wake(standby_wake)
  );

  smc_settle_timer #(
    .EXP_C0(SETTLE_EXP_C0),
    .EXP_C1(SETTLE_EXP_C1),
    .EXP_C2(SETTLE_EXP_C2)
  ) u_settle (
    .pclk(pclk),
    .presetn(presetn),
    .start(s_r.settle_go),
    .code(s_r.settle_sel[2:0]),
    .osc_running(osc_running),
    .done(settle_done)
  );

  // 0 control, 1 mode, 2 settle select, 3 status; valid flag in bit 2
  function automatic logic [2:0] reg_decode(input logic [31:0] a);
    case (a)
      `SMC_PWR_CTL_ADDR: return 3'h4;
      `SMC_PWR_MODE_ADDR: return 3'h5;
      `SMC_SETTLE_SEL_ADDR: return 3'h6;
      `SMC_STAT_ADDR: return 3'h7;
      default: return 3'h0;
    endcase
  endfunction

  logic [2:0] sel;
  logic xfer;
  logic wr_ok;
  logic [7:0] ctl_view;

  always_comb begin
    s_nxt = s_r;
    s_nxt.settle_go = 1'b0;
    sel = reg_decode(paddr);
    ctl_view = 8'h00;
    ctl_view[`SMC_STBY_REQ_BIT] = s_r.stby_req;
    ctl_view[`SMC_INTDIS_BIT] = s_r.int_wake_dis;
    // one wait state: pready rises in the second access cycle
    s_nxt.pready = psel && penable && !s_r.pready;
    s_nxt.pslverr = 1'b0;
    s_nxt.prdata = 32'h0;
    if (psel && penable && !s_r.pready) begin
      s_nxt.pslverr = !sel[2];
      if (!pwrite) begin
        case (sel)
          3'h4: s_nxt.prdata = {24'h0, ctl_view};
          3'h5: s_nxt.prdata = {24'h0, s_r.pwr_mode};
          3'h6: s_nxt.prdata = {24'h0, s_r.settle_sel};
          3'h7: s_nxt.prdata = {29'h0, s_r.state};
          default: s_nxt.prdata = 32'h0;
        endcase
      end
    end
    xfer = psel && penable && s_r.pready;
    // bit-unit access arrives as a byte read-modify-write from the cpu
    wr_ok = xfer && pwrite && !s_r.pslverr && pstrb[0];
    if (wr_ok) begin
      case (sel)
        3'h4: begin
          s_nxt.stby_req = pwdata[`SMC_STBY_REQ_BIT];
          s_nxt.int_wake_dis = pwdata[`SMC_INTDIS_BIT];
        end
        // unused bits are held at zero so a careless write cannot leave junk
        3'h5: s_nxt.pwr_mode = pwdata[7:0] & `SMC_PWR_MODE_WMASK;
        3'h6: s_nxt.settle_sel = pwdata[7:0] & `SMC_SETTLE_SEL_WMASK;
        default: s_nxt.pwr_mode = s_r.pwr_mode;
      endcase
    end

    case (s_r.state)
      SMC_RUN: begin
        // mode register is sampled here, after software has already written it
        if (s_r.stby_req) begin
          s_nxt.state = s_r.pwr_mode[`SMC_STOP_SEL_BIT] ? SMC_STOP : SMC_IDLE;
        end else if (halt_instr) begin
          s_nxt.state = SMC_HALT;
        end
      end
      SMC_HALT: begin
        // a request already pending makes this a single cycle stay
        if (halt_wake) begin
          s_nxt.state = SMC_RUN;
        end
      end
      SMC_IDLE: begin
        if (standby_wake) begin
          s_nxt.state = SMC_RUN;
          s_nxt.stby_req = 1'b0;
        end
      end
      SMC_STOP: begin
        if (standby_wake) begin
          s_nxt.state = SMC_SETTLE;
          s_nxt.settle_go = 1'b1;
        end
      end
      SMC_SETTLE: begin
        if (settle_done) begin
          s_nxt.state = SMC_RUN;
          s_nxt.stby_req = 1'b0;
        end
      end
      default: s_nxt.state = SMC_RUN;
    endcase

    // gates follow the next state so outputs stay pure flip-flops
    s_nxt.cpu_clk_en = (s_nxt.state == SMC_RUN);
    s_nxt.periph_clk_en = (s_nxt.state == SMC_RUN) || (s_nxt.state == SMC_HALT);
    s_nxt.main_osc_en = (s_nxt.state != SMC_STOP);
    s_nxt.subclk_osc_en = !s_nxt.pwr_mode[`SMC_SUBCLK_DIS_BIT];
  end

  // reset starts in settle with code 001 already loaded
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r.state <= SMC_SETTLE;
      s_r.stby_req <= 1'b0;
      s_r.int_wake_dis <= 1'b0;
      s_r.pwr_mode <= `SMC_PWR_MODE_RST;
      s_r.settle_sel <= `SMC_SETTLE_SEL_RST;
      s_r.settle_go <= 1'b1;
      s_r.cpu_clk_en <= 1'b0;
      s_r.periph_clk_en <= 1'b0;
      s_r.main_osc_en <= 1'b1;
      s_r.subclk_osc_en <= 1'b1;
      s_r.pready <= 1'b0;
      s_r.pslverr <= 1'b0;
      s_r.prdata <= 32'h0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata = s_r.prdata;
  assign pready = s_r.pready;
  assign pslverr = s_r.pslverr;
  assign cpu_clk_en = s_r.cpu_clk_en;
  assign periph_clk_en = s_r.periph_clk_en;
  assign main_osc_en = s_r.main_osc_en;
  assign subclk_osc_en = s_r.subclk_osc_en;
  assign mode = s_r.state;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  standby_entry_a: assert property (s_r.state == SMC_RUN && s_r.stby_req |=>
      s_r.state inside {SMC_IDLE, SMC_STOP} && !cpu_clk_en)
    else $error("standby request did not enter standby");
  stop_select_a: assert property (s_r.state == SMC_RUN && s_r.stby_req && s_r.pwr_mode[0] |=>
      s_r.state == SMC_STOP ##1 !main_osc_en)
    else $error("stop select not honoured");
  select_ignored_a: assert property (s_r.state == SMC_RUN && !s_r.stby_req && !halt_instr |=>
      s_r.state == SMC_RUN && cpu_clk_en)
    else $error("left normal operation without request");
  mode_write_a: assert property (psel && penable && pready && pwrite && pstrb[0] &&
      paddr == `SMC_PWR_MODE_ADDR |=> s_r.pwr_mode == (8'(pwdata) & 8'h81) &&
      subclk_osc_en == !$past(pwdata[7]))
    else $error("power save mode write not applied");
  settle_reset_a: assert property ($rose(presetn) |-> s_r.settle_sel == 8'h01)
    else $error("settle select not at reset value");
  halt_entry_a: assert property (s_r.state == SMC_RUN && !s_r.stby_req && halt_instr |=>
      s_r.state == SMC_HALT && !cpu_clk_en)
    else $error("halt instruction not taken");
  halt_clocks_a: assert property (s_r.state == SMC_HALT |->
      !cpu_clk_en && periph_clk_en && main_osc_en)
    else $error("wrong clock gates in halt");
  halt_release_a: assert property (s_r.state == SMC_HALT && (nmi_req || int_req) |=>
      s_r.state == SMC_RUN ##1 cpu_clk_en)
    else $error("halt not released by request");
  settle_gate_a: assert property (s_r.state == SMC_SETTLE |-> !cpu_clk_en)
    else $error("cpu clock running during settle");
  apb_answer_a: assert property (psel && penable && !pready |=> pready)
    else $error("apb answer late");

  halt_cycle_c: cover property (s_r.state == SMC_RUN ##1 s_r.state == SMC_HALT
      ##1 s_r.state == SMC_RUN);
  idle_cycle_c: cover property (s_r.state == SMC_IDLE ##1 s_r.state == SMC_RUN);
  stop_settle_c: cover property (s_r.state == SMC_STOP ##1 s_r.state == SMC_SETTLE);
  settle_done_c: cover property (s_r.state == SMC_SETTLE ##1 s_r.state == SMC_RUN);

endmodule
`default_nettype wire

// ==== sim/smc_cpu_model.sv ====
// behavioural main oscillator and cpu halt source facing the controller
`timescale 1ns/1ps
`default_nettype none
module smc_cpu_model #(
  parameter int START_CYC = 5
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // controls
  input wire logic main_osc_en,
  input wire logic halt_go,
  // to controller
  output logic osc_running,
  output logic halt_instr
);
  int cnt;
  // start-up delay so a settle count that ignores it shows up as too short
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      osc_running <= 1'b0;
      halt_instr <= 1'b0;
    end else begin
      halt_instr <= halt_go;
      if (!main_osc_en) begin
        cnt <= 0;
        osc_running <= 1'b0;
      end else if (cnt < START_CYC) begin
        cnt <= cnt + 1;
      end else begin
        osc_running <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== sim/tb.sv ====
// self-checking bench for the standby mode controller
`timescale 1ns/1ps
`default_nettype none
`include "smc_consts.svh"
module tb;
  import smc_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, e;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, r;
  logic [3:0] pstrb = 4'hf;
  logic halt_go = 1'b0, nmi_req = 1'b0, int_req = 1'b0;
  logic halt_instr, osc_running, main_osc_en, subclk_osc_en;
  logic cpu_clk_en, periph_clk_en, pready, pslverr;
  logic [2:0] mode;
  int errors = 0, checks = 0, settle_n = 0, x;

  always #4 pclk = ~pclk;
  always @(posedge pclk) if (mode === 3'h4 && osc_running === 1'b1) settle_n <= settle_n + 1;

  smc_standby_ctrl #(.SETTLE_EXP_C0(2), .SETTLE_EXP_C1(3), .SETTLE_EXP_C2(4)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .halt_instr(halt_instr), .nmi_req(nmi_req), .int_req(int_req),
    .osc_running(osc_running), .main_osc_en(main_osc_en), .subclk_osc_en(subclk_osc_en),
    .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en), .mode(mode));
  smc_cpu_model cpu (.pclk(pclk), .presetn(presetn), .main_osc_en(main_osc_en),
    .halt_go(halt_go), .osc_running(osc_running), .halt_instr(halt_instr));

  task chk(input logic [31:0] g, input logic [31:0] v);
    checks++;
    if (g !== v) begin
      errors++;
      $display("BAD %0t got %h exp %h", $time, g, v);
    end
  endtask
  task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) chk(pready, 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd(input logic [31:0] a, input logic [31:0] v);
    apb(1'b0, a, 32'h0);
    chk(r, v);
  endtask
  // bounded wait for a mode, sampled after the edge has settled
  task wm(input logic [2:0] m);
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      #1;
      n++;
    end while (mode !== m && n < 3000);
    chk(mode, m);
  endtask
  function int ex(int c);
    return c == 0 ? 2 : (c == 1 ? 3 : 4 + c - 2);
  endfunction
  task finish_test;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    #(20000 * 8);
    errors++;
    $display("BAD %0t watchdog expired", $time);
    finish_test;
  end

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    wm(3'h0);
    chk(32'(settle_n), 32'd9);
    rd(`SMC_PWR_MODE_ADDR, 32'h00);
    rd(`SMC_SETTLE_SEL_ADDR, 32'h01);
    $display("test reset done");
    apb(1'b1, `SMC_PWR_MODE_ADDR, 32'h81);
    rd(`SMC_PWR_MODE_ADDR, 32'h81);
    chk(subclk_osc_en, 1'b0);
    apb(1'b1, `SMC_PWR_MODE_ADDR, 32'h00);
    rd(`SMC_PWR_MODE_ADDR, 32'h00);
    chk(subclk_osc_en, 1'b1);
    pstrb <= 4'he;
    apb(1'b1, `SMC_SETTLE_SEL_ADDR, 32'h05);
    pstrb <= 4'hf;
    rd(`SMC_SETTLE_SEL_ADDR, 32'h01);
    apb(1'b1, `SMC_SETTLE_SEL_ADDR, 32'h07);
    rd(`SMC_SETTLE_SEL_ADDR, 32'h07);
    rd(32'hfffff808, 32'h0);
    chk(e, 1'b1);
    $display("test registers done");
    apb(1'b1, `SMC_PWR_MODE_ADDR, 32'h01);
    repeat (6) @(posedge pclk);
    #1;
    chk(mode, 3'h0);
    halt_go <= 1'b1;
    @(posedge pclk) halt_go <= 1'b0;
    wm(3'h1);
    chk({cpu_clk_en, periph_clk_en, main_osc_en}, 3'b011);
    rd(`SMC_PWR_MODE_ADDR, 32'h01);
    chk(mode, 3'h1);
    @(posedge pclk) int_req <= 1'b1;
    wm(3'h0);
    @(posedge pclk) halt_go <= 1'b1;
    @(posedge pclk) halt_go <= 1'b0;
    wm(3'h1);
    @(posedge pclk);
    #1;
    chk(mode, 3'h0);
    int_req <= 1'b0;
    apb(1'b1, `SMC_PWR_MODE_ADDR, 32'h00);
    apb(1'b1, `SMC_PWR_CTL_ADDR, 32'h02);
    wm(3'h2);
    chk({cpu_clk_en, main_osc_en}, 2'b01);
    @(posedge pclk) int_req <= 1'b1;
    wm(3'h0);
    int_req <= 1'b0;
    rd(`SMC_PWR_CTL_ADDR, 32'h00);
    apb(1'b1, `SMC_PWR_CTL_ADDR, 32'h12);
    wm(3'h2);
    int_req <= 1'b1;
    repeat (8) @(posedge pclk);
    #1;
    chk(mode, 3'h2);
    nmi_req <= 1'b1;
    wm(3'h0);
    nmi_req <= 1'b0;
    int_req <= 1'b0;
    $display("test halt and idle done");
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, `SMC_SETTLE_SEL_ADDR, 32'(c));
      apb(1'b1, `SMC_PWR_MODE_ADDR, 32'h01);
      apb(1'b1, `SMC_PWR_CTL_ADDR, 32'h02);
      wm(3'h3);
      chk({cpu_clk_en, main_osc_en}, 2'b00);
      x = settle_n;
      @(posedge pclk) nmi_req <= 1'b1;
      wm(3'h4);
      nmi_req <= 1'b0;
      wm(3'h0);
      chk(32'(settle_n - x), 32'((1 << ex(c)) + 1));
    end
    $display("test stop done");
    finish_test;
  end
endmodule
`default_nettype wire
